/* logic/somsr_stage.v */
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "somsr_regs.vh"
// What this block does
// - staging register is write-only holding location
// - no writes in reset or low power
// - alignment field b000 lets bursts cross
// - alignment codes split 32/64/128/256 beats
// - strobe select 0: chip select timing
// - strobe select 1: write strobe timing
// - address valid bit enables latch strobe
// - burst advance bit enables advance strobe
// - bits 9:7 write burst length code
// - write sync bit selects synchronous writes
// - bits 5:3 read burst length code
// - read sync bit selects synchronous reads
// - width code 8/16/32 bits, b11 reserved
// - async reads align to memory burst boundary
// - async writes align to memory burst boundary
// - commit copies staging to selected chip
// - bus-write commit needs low-half data match
// - combined command commits with config write
module somsr_stage (
	input wire CLK,
	input wire RST,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	output wire PREADY,
	output reg [31:0] PRDATA,
	output wire PSLVERR,
	input wire LOW_POWER,
	input wire CTRL_RESET_STATE,
	input wire MEM_BUS_WRITE,
	input wire [31:0] MEM_BUS_WDATA,
	input wire CFG_WRITE_DONE,
	output reg CFG_WRITE_REQ,
	input wire [2:0] ACTIVE_CHIP,
	output reg ACTIVE_BLS_WE_TIMING,
	output reg ACTIVE_ADV_USE,
	output reg ACTIVE_BAA_USE,
	output reg ACTIVE_WR_SYNC,
	output reg ACTIVE_RD_SYNC,
	output wire [8:0] ACTIVE_RD_SPLIT,
	output wire [8:0] ACTIVE_WR_SPLIT,
	output wire [8:0] ACTIVE_WR_BEATS,
	output wire [8:0] ACTIVE_RD_BEATS,
	output wire ACTIVE_WR_CONT,
	output wire ACTIVE_RD_CONT,
	output wire [5:0] ACTIVE_BUS_BITS,
	output reg COMMIT_PULSE
);
	localparam ST_IDLE = 3'b001;
	localparam ST_ARMED = 3'b010;
	localparam ST_WAITCFG = 3'b100;

	reg [15:0] stage_ff;
	reg [15:0] mode_ff [0:`SOMSR_NCHIP-1];
	reg [31:0] dcmd_ff;
	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [2:0] tgt_ff;
	reg [2:0] nxt_tgt;
	reg nxt_cfg_req;
	reg commit_now;
	reg [15:0] active_mode;
	wire [8:0] dec_split;
	wire blocked;
	wire bus_wr;
	wire bus_rd;
	wire [1:0] ct;
	wire [2:0] cs;
	wire is_mode_addr;
	wire [2:0] mode_idx;
	wire addr_ok;

	assign blocked = LOW_POWER | CTRL_RESET_STATE;
	assign bus_wr = PSEL & PENABLE & PWRITE;
	assign bus_rd = PSEL & PENABLE & ~PWRITE;
	assign PREADY = 1'b1;
	assign ct = PWDATA[`SOMSR_CT_HI:`SOMSR_CT_LO];
	assign cs = PWDATA[`SOMSR_CS_HI:`SOMSR_CS_LO];
	assign is_mode_addr = (PADDR[11:5] == `SOMSR_ADDR_MODE0 >> 5) && (PADDR[1:0] == 2'h0);
	assign mode_idx = PADDR[4:2];
	assign addr_ok = (PADDR == `SOMSR_ADDR_STAGE) || (PADDR == `SOMSR_ADDR_DCMD) ||
		(PADDR == `SOMSR_ADDR_STAT) || is_mode_addr;
	// staging and command writes refused while blocked; only staging writes are flagged
	assign PSLVERR = PSEL & PENABLE & (~addr_ok | (PWRITE & blocked & (PADDR == `SOMSR_ADDR_STAGE)) |
		(PWRITE & is_mode_addr) | (~PWRITE & (PADDR == `SOMSR_ADDR_STAGE)));

	// staging register: upper half dropped, held until next write
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			stage_ff <= `SOMSR_ZERO16;
		end else if (bus_wr && PADDR == `SOMSR_ADDR_STAGE && !blocked) begin
			stage_ff <= PWDATA[`SOMSR_MODE_W-1:0];
		end
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			dcmd_ff <= 32'h00000000;
		end else if (bus_wr && PADDR == `SOMSR_ADDR_DCMD && !blocked && state_ff == ST_IDLE) begin
			// an armed command keeps its match value until it fires
			dcmd_ff <= PWDATA;
		end
	end

	// command sequencing
	always @* begin
		nxt_state = state_ff;
		nxt_tgt = tgt_ff;
		nxt_cfg_req = 1'b0;
		commit_now = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (bus_wr && PADDR == `SOMSR_ADDR_DCMD && !blocked) begin
					nxt_tgt = cs;
					if (ct == `SOMSR_CT_COMMIT) begin
						commit_now = 1'b1;
					end else if (ct == `SOMSR_CT_BUSMATCH) begin
						nxt_state = ST_ARMED;
					end else if (ct == `SOMSR_CT_BOTH) begin
						nxt_state = ST_WAITCFG;
						nxt_cfg_req = 1'b1;
					end else begin
						nxt_cfg_req = 1'b1;
					end
				end
			end
			ST_ARMED: begin
				if (MEM_BUS_WRITE &&
					MEM_BUS_WDATA[`SOMSR_MATCH_HI:`SOMSR_MATCH_LO] ==
					dcmd_ff[`SOMSR_MATCH_HI:`SOMSR_MATCH_LO]) begin
					commit_now = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			ST_WAITCFG: begin
				// commit lands in the same cycle as the memory config write
				if (CFG_WRITE_DONE) begin
					commit_now = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_ff <= ST_IDLE;
			tgt_ff <= 3'h0;
			CFG_WRITE_REQ <= 1'b0;
			COMMIT_PULSE <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			tgt_ff <= nxt_tgt;
			CFG_WRITE_REQ <= nxt_cfg_req;
			COMMIT_PULSE <= commit_now;
		end
	end

	// per-chip active mode registers
	genvar g;
	generate
		for (g = 0; g < `SOMSR_NCHIP; g = g + 1) begin : g_chip
			always @(posedge CLK or posedge RST) begin
				if (RST) begin
					mode_ff[g] <= `SOMSR_ZERO16;
				end else if (commit_now && nxt_tgt == g) begin
					mode_ff[g] <= stage_ff;
				end
			end
		end
	endgenerate

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			PRDATA <= 32'h00000000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			if (is_mode_addr) begin
				PRDATA <= {16'h0000, mode_ff[mode_idx]};
			end else if (PADDR == `SOMSR_ADDR_STAT) begin
				PRDATA <= {26'h0000000, tgt_ff, state_ff};
			end else begin
				// staging is write-only and reads as zero
				PRDATA <= 32'h00000000;
			end
		end
	end

	// only committed values reach the memory side
	always @* begin
		active_mode = mode_ff[ACTIVE_CHIP];
		ACTIVE_BLS_WE_TIMING = active_mode[`SOMSR_BLS];
		ACTIVE_ADV_USE = active_mode[`SOMSR_ADV];
		ACTIVE_BAA_USE = active_mode[`SOMSR_BAA];
		ACTIVE_WR_SYNC = active_mode[`SOMSR_WSYNC];
		ACTIVE_RD_SYNC = active_mode[`SOMSR_RSYNC];
	end

	somsr_decode u_dec (
		.MODE(active_mode),
		.BURST_SPLIT(dec_split),
		.WR_BEATS(ACTIVE_WR_BEATS),
		.RD_BEATS(ACTIVE_RD_BEATS),
		.WR_CONT(ACTIVE_WR_CONT),
		.RD_CONT(ACTIVE_RD_CONT),
		.BUS_BITS(ACTIVE_BUS_BITS),
		.CODE_ERR()
	);

	// async transfers fall back to the 32-beat memory boundary
	assign ACTIVE_RD_SPLIT = ACTIVE_RD_SYNC ? dec_split : `SOMSR_SPLIT_MEM;
	assign ACTIVE_WR_SPLIT = ACTIVE_WR_SYNC ? dec_split : `SOMSR_SPLIT_MEM;
endmodule // somsr_stage

/* logic/somsr_regs.vh */
`ifndef SOMSR_REGS_VH
`define SOMSR_REGS_VH
// byte addresses
`define SOMSR_ADDR_STAGE 12'h014
`define SOMSR_ADDR_DCMD 12'h010
`define SOMSR_ADDR_STAT 12'h000
`define SOMSR_ADDR_MODE0 12'h100
// staging field positions
`define SOMSR_BA_HI 15
`define SOMSR_BA_LO 13
`define SOMSR_BLS 12
`define SOMSR_ADV 11
`define SOMSR_BAA 10
`define SOMSR_WBL_HI 9
`define SOMSR_WBL_LO 7
`define SOMSR_WSYNC 6
`define SOMSR_RBL_HI 5
`define SOMSR_RBL_LO 3
`define SOMSR_RSYNC 2
`define SOMSR_MW_HI 1
`define SOMSR_MW_LO 0
`define SOMSR_MODE_W 16
// direct command fields
`define SOMSR_CS_HI 25
`define SOMSR_CS_LO 23
`define SOMSR_CT_HI 22
`define SOMSR_CT_LO 21
`define SOMSR_MATCH_HI 15
`define SOMSR_MATCH_LO 0
// command types
`define SOMSR_CT_BUSMATCH 2'h0
`define SOMSR_CT_CFGWR 2'h1
`define SOMSR_CT_COMMIT 2'h2
`define SOMSR_CT_BOTH 2'h3
// codes
`define SOMSR_BA_ANY 3'h0
`define SOMSR_BA_MEM 3'h1
`define SOMSR_BA_64 3'h2
`define SOMSR_BA_128 3'h3
`define SOMSR_BA_256 3'h4
`define SOMSR_BL_1 3'h0
`define SOMSR_BL_4 3'h1
`define SOMSR_BL_8 3'h2
`define SOMSR_BL_16 3'h3
`define SOMSR_BL_32 3'h4
`define SOMSR_BL_CONT 3'h5
`define SOMSR_MW_8 2'h0
`define SOMSR_MW_16 2'h1
`define SOMSR_MW_32 2'h2
`define SOMSR_NCHIP 8
`define SOMSR_ZERO16 16'h0000
`define SOMSR_SPLIT_MEM 9'h020
`endif

/* logic/somsr_decode.v */
`timescale 1ns/1ps
`include "somsr_regs.vh"
module somsr_decode (
	input wire [15:0] MODE,
	output reg [8:0] BURST_SPLIT,
	output reg [8:0] WR_BEATS,
	output reg [8:0] RD_BEATS,
	output reg WR_CONT,
	output reg RD_CONT,
	output reg [5:0] BUS_BITS,
	output reg CODE_ERR
);
	function [8:0] bl_beats;
		input [2:0] c;
		begin
			case (c)
				`SOMSR_BL_1: bl_beats = 9'h001;
				`SOMSR_BL_4: bl_beats = 9'h004;
				`SOMSR_BL_8: bl_beats = 9'h008;
				`SOMSR_BL_16: bl_beats = 9'h010;
				`SOMSR_BL_32: bl_beats = 9'h020;
				`SOMSR_BL_CONT: bl_beats = 9'h020;
				default: bl_beats = 9'h000;
			endcase
		end
	endfunction
	wire [2:0] ba = MODE[`SOMSR_BA_HI:`SOMSR_BA_LO];
	wire [2:0] wbl = MODE[`SOMSR_WBL_HI:`SOMSR_WBL_LO];
	wire [2:0] rbl = MODE[`SOMSR_RBL_HI:`SOMSR_RBL_LO];
	wire [1:0] mw = MODE[`SOMSR_MW_HI:`SOMSR_MW_LO];
	always @* begin
		WR_BEATS = bl_beats(wbl);
		RD_BEATS = bl_beats(rbl);
		WR_CONT = (wbl == `SOMSR_BL_CONT);
		RD_CONT = (rbl == `SOMSR_BL_CONT);
		// zero split means no boundary
		case (ba)
			`SOMSR_BA_ANY: BURST_SPLIT = 9'h000;
			`SOMSR_BA_MEM: BURST_SPLIT = 9'h020;
			`SOMSR_BA_64: BURST_SPLIT = 9'h040;
			`SOMSR_BA_128: BURST_SPLIT = 9'h080;
			`SOMSR_BA_256: BURST_SPLIT = 9'h100;
			default: BURST_SPLIT = 9'h000;
		endcase
		case (mw)
			`SOMSR_MW_8: BUS_BITS = 6'h08;
			`SOMSR_MW_16: BUS_BITS = 6'h10;
			`SOMSR_MW_32: BUS_BITS = 6'h20;
			default: BUS_BITS = 6'h00;
		endcase
		CODE_ERR = (ba > `SOMSR_BA_256) || (wbl > `SOMSR_BL_CONT) || (rbl > `SOMSR_BL_CONT) || (mw == 2'h3);
	end
endmodule // somsr_decode

/* sim/somsr_stage_sva.sv */
`timescale 1ns/1ps
module somsr_stage_sva (
	input wire CLK,
	input wire RST,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PRDATA,
	input wire PSLVERR,
	input wire LOW_POWER,
	input wire CTRL_RESET_STATE,
	input wire [2:0] ACTIVE_CHIP,
	input wire ACTIVE_WR_SYNC,
	input wire ACTIVE_RD_SYNC,
	input wire [8:0] ACTIVE_RD_SPLIT,
	input wire [8:0] ACTIVE_WR_SPLIT,
	input wire [8:0] ACTIVE_RD_BEATS,
	input wire ACTIVE_RD_CONT,
	input wire [5:0] ACTIVE_BUS_BITS,
	input wire CFG_WRITE_REQ,
	input wire COMMIT_PULSE
);
	wire stg_acc = PSEL & PENABLE & (PADDR == 12'h014);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	a_async_rd_split: assert property (!ACTIVE_RD_SYNC |-> ACTIVE_RD_SPLIT == 9'h020) else $error("rd split");
	a_async_wr_split: assert property (!ACTIVE_WR_SYNC |-> ACTIVE_WR_SPLIT == 9'h020) else $error("wr split");
	a_cont_beats: assert property (ACTIVE_RD_CONT |-> ACTIVE_RD_BEATS == 9'h020) else $error("cont beats");
	a_stage_refused: assert property (stg_acc && PWRITE && (LOW_POWER || CTRL_RESET_STATE) |-> PSLVERR)
		else $error("refuse");
	a_stage_wonly: assert property (stg_acc && !PWRITE |-> PSLVERR && PRDATA == 32'h00000000)
		else $error("wonly");
	a_commit_once: assert property (COMMIT_PULSE |=> !COMMIT_PULSE) else $error("commit pulse");
	a_cfg_once: assert property ($rose(CFG_WRITE_REQ) |=> $fell(CFG_WRITE_REQ)) else $error("cfg pulse");
	// mode outputs may only move on a commit or a chip change
	a_mode_inert: assert property ($stable(ACTIVE_CHIP) && !COMMIT_PULSE |->
		$stable(ACTIVE_BUS_BITS) && $stable(ACTIVE_RD_BEATS)) else $error("inert");
	c_commit: cover property (COMMIT_PULSE);
	c_refused: cover property (stg_acc && PWRITE && LOW_POWER);
	c_cfg: cover property (CFG_WRITE_REQ);
endmodule // somsr_stage_sva

/* sim/somsr_stage_test.sv */
`timescale 1ns/1ps
`define CK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin err_total++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module somsr_stage_test;
	reg CLK, RST, PSEL, PENABLE, PWRITE, LOW_POWER, CTRL_RESET_STATE, MEM_BUS_WRITE, CFG_WRITE_DONE, se;
	reg [11:0] PADDR;
	reg [31:0] PWDATA, MEM_BUS_WDATA, rd;
	reg [2:0] ACTIVE_CHIP;
	wire PREADY, PSLVERR, CFG_WRITE_REQ, COMMIT_PULSE, ACTIVE_BLS_WE_TIMING, ACTIVE_ADV_USE, ACTIVE_BAA_USE;
	wire ACTIVE_WR_SYNC, ACTIVE_RD_SYNC, ACTIVE_WR_CONT, ACTIVE_RD_CONT;
	wire [31:0] PRDATA;
	wire [8:0] ACTIVE_RD_SPLIT, ACTIVE_WR_SPLIT, ACTIVE_WR_BEATS, ACTIVE_RD_BEATS;
	wire [5:0] ACTIVE_BUS_BITS;
	integer err_total = 0, cmp_count = 0, nreq = 0, ncm = 0, i, s, stg;
	integer md[0:7];
	somsr_stage u_somsr_stage (.*);
	always @(posedge CLK) if (CFG_WRITE_REQ === 1'b1) nreq <= nreq + 1;
	always @(posedge CLK) if (COMMIT_PULSE === 1'b1) ncm <= ncm + 1;
	function integer bl(input [2:0] c);
		bl = c == 0 ? 1 : c < 5 ? 2 << c : c == 5 ? 32 : 0;
	endfunction
	// synchronous split size: 32, 64, 128, 256 beats; none for b000 and reserved codes
	function integer sp(input [2:0] c);
		sp = c == 0 ? 0 : c < 5 ? 16 << c : 0;
	endfunction
	task close_out;
		if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task xfer(input w, input [11:0] a, input [31:0] d);
		integer n;
		PSEL <= 1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 16);
		if (n >= 16) begin
			err_total++;
			close_out;
		end
		rd = PRDATA;
		se = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
		@(posedge CLK);
	endtask
	task cm(input [1:0] t, input [2:0] c, input [15:0] m);
		xfer(1, 12'h010, {6'h00, c, t, 5'h00, m});
	endtask
	task chk(input [2:0] c);
		integer m;
		m = md[c];
		ACTIVE_CHIP <= c;
		@(posedge CLK);
		`CK("bits", m[1:0] == 0 ? 8 : m[1:0] == 1 ? 16 : m[1:0] == 2 ? 32 : 0, ACTIVE_BUS_BITS)
		`CK("rbl", bl(m[5:3]), ACTIVE_RD_BEATS)
		`CK("wbl", bl(m[9:7]), ACTIVE_WR_BEATS)
		`CK("cont", {m[9:7] == 5, m[5:3] == 5}, {ACTIVE_WR_CONT, ACTIVE_RD_CONT})
		`CK("flags", m[12:10], {ACTIVE_BLS_WE_TIMING, ACTIVE_ADV_USE, ACTIVE_BAA_USE})
		`CK("sync", {m[6], m[2]}, {ACTIVE_WR_SYNC, ACTIVE_RD_SYNC})
		`CK("rsplit", m[2] ? sp(m[15:13]) : 32, ACTIVE_RD_SPLIT)
		`CK("wsplit", m[6] ? sp(m[15:13]) : 32, ACTIVE_WR_SPLIT)
		xfer(0, 12'h100 + 4 * c, 0);
		`CK("mode", m, rd)
	endtask
	initial begin
		CLK = 0;
		forever #4 CLK = ~CLK;
	end
	initial begin
		{RST, PSEL, PENABLE, PWRITE, LOW_POWER, CTRL_RESET_STATE, MEM_BUS_WRITE, CFG_WRITE_DONE} = 8'h80;
		PADDR = 0;
		PWDATA = 0;
		MEM_BUS_WDATA = 0;
		ACTIVE_CHIP = 0;
		for (i = 0; i < 8; i++) md[i] = 0;
		s = $urandom(38871);
		repeat (10) @(posedge CLK);
		RST <= 0;
		@(posedge CLK);
		for (i = 0; i < 8; i++) begin
			stg = $urandom & 32'h0000FFFC;
			stg = stg | ($urandom % 2 + 1);
			if (i == 7)
				stg = $urandom % 2;
			xfer(1, 12'h014, stg);
			cm(2'h2, i[2:0], 16'h0000);
			md[i] = stg;
			chk(i[2:0]);
		end
		// refused writes and commands must leave the old staged value and modes alone
		for (i = 1; i < 3; i++) begin
			{CTRL_RESET_STATE, LOW_POWER} <= i[1:0];
			@(posedge CLK);
			xfer(1, 12'h014, stg ^ 32'h0000FFF0);
			`CK("refuse", 1, se)
			cm(2'h2, 3'h3, 16'h0000);
			{CTRL_RESET_STATE, LOW_POWER} <= 0;
			cm(2'h2, 3'h0, 16'h0000);
			md[0] = stg;
			chk(0);
			chk(3);
		end
		xfer(0, 12'h014, 0);
		`CK("wonly", {1'b1, 32'h0}, {se, rd})
		stg = $urandom & 32'h0000FFFC;
		stg = stg | 32'h00000002;
		s = stg ^ 32'h00005A5A;
		xfer(1, 12'h014, stg);
		cm(2'h0, 3'h1, s[15:0]);
		MEM_BUS_WRITE <= 1;
		MEM_BUS_WDATA <= ~s;
		@(posedge CLK);
		MEM_BUS_WRITE <= 0;
		chk(1);
		MEM_BUS_WRITE <= 1;
		MEM_BUS_WDATA <= ($urandom << 16) | s;
		@(posedge CLK);
		MEM_BUS_WRITE <= 0;
		md[1] = stg;
		chk(1);
		xfer(1, 12'h014, stg ^ 32'h0000FFF0);
		cm(2'h1, 3'h2, 16'h0000);
		cm(2'h3, 3'h2, 16'h0000);
		chk(2);
		`CK("cfgreq", 2, nreq)
		CFG_WRITE_DONE <= 1;
		@(posedge CLK);
		CFG_WRITE_DONE <= 0;
		md[2] = stg ^ 32'h0000FFF0;
		chk(2);
		`CK("commits", 12, ncm)
		close_out;
	end
endmodule // somsr_stage_test
bind somsr_stage somsr_stage_sva u_somsr_stage_sva (.*);
